// ==== rac_alarm_control.sv ====
/*
  Alarm control register of the real-time clock, with APB slave, repeat
  counter, alarm pulse, read-unsafe flag and interrupt logic. Assumes srst
  is the power-on reset, sys_rst any other reset, and that the calendar
  provides rollover strobes and the prescaler distance to rollover.
*/
`timescale 1ns/10ps
`default_nettype none
module rac_alarm_control
  import rac_pkg::*;
#(
  parameter int unsigned PRESC_W = 15,
  parameter int unsigned NUM_INTV = RAC_NUM_INTV
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INTV-1:0] rollover_strobe,
  input wire logic alarm_feb29,
  input wire logic leap_year,
  input wire logic [PRESC_W-1:0] ticks_to_rollover,
  input wire logic clock_module_on,
  output logic alarm_pulse,
  output logic irq
);

  // The prescaler distance must be able to hold the guard window.
  if (PRESC_W < 6 || PRESC_W > 31) begin : g_chk
    $error("rac_alarm_control: PRESC_W must be 6 to 31");
  end

  rac_apb_st_t st_r, st_nxt;
  rac_apb_req_t req;
  rac_ctrl_t ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt, rd_word;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic unsafe_r, unsafe_nxt;
  logic [RAC_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, stat_set;
  logic irq_r, irq_nxt;
  logic addr_hit, wr_go, wr_ctrl, wr_stat, wr_mask;
  logic sel_fire, alarm_evt, auto_off;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign alarm_pulse = ctrl_r.pulse_init;
  assign irq = irq_r;

  // Address decode and commit strobes; a write lands on the completing edge.
  assign addr_hit = (req.addr == RAC_OFF_CTRL) || (req.addr == RAC_OFF_IRQ_STAT) ||
                    (req.addr == RAC_OFF_IRQ_MASK);
  assign wr_go = (st_r == RAC_ST_ANS) && psel && penable && pready_r && req.write;
  assign wr_ctrl = wr_go && (req.addr == RAC_OFF_CTRL);
  assign wr_stat = wr_go && (req.addr == RAC_OFF_IRQ_STAT);
  assign wr_mask = wr_go && (req.addr == RAC_OFF_IRQ_MASK);

  // Read word assembly; the top half of the control word is always zero.
  always_comb begin
    rd_word = 32'h0000_0000; // [RQ13]
    case (req.addr)
      RAC_OFF_CTRL: begin
        rd_word[RAC_BIT_ENABLE] = ctrl_r.enable;
        rd_word[RAC_BIT_WRAP] = ctrl_r.wrap;
        rd_word[RAC_BIT_PULSE_INIT] = ctrl_r.pulse_init; // [RQ6]
        rd_word[RAC_BIT_UNSAFE] = unsafe_r; // [RQ8]
        rd_word[RAC_INTV_LSB+:4] = ctrl_r.interval;
        rd_word[RAC_CNT_LSB+:8] = ctrl_r.count;
      end
      RAC_OFF_IRQ_STAT: begin
        rd_word[RAC_IRQ_W-1:0] = stat_r;
      end
      RAC_OFF_IRQ_MASK: begin
        rd_word[RAC_IRQ_W-1:0] = mask_r;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Bus sequencer: the setup edge loads the answer, so pready is high
  // throughout the first access cycle and transfers take two cycles.
  always_comb begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    case (st_r)
      RAC_ST_IDLE: begin
        if (psel && !penable) begin
          st_nxt = RAC_ST_ANS;
          pready_nxt = 1'b1;
          pslverr_nxt = !addr_hit;
          prdata_nxt = req.write ? 32'h0000_0000 : rd_word;
        end
      end
      RAC_ST_ANS: begin
        st_nxt = RAC_ST_IDLE;
      end
      default: begin
        st_nxt = RAC_ST_IDLE;
      end
    endcase
  end

  // The bus side answers only to the power-on reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= RAC_ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Interval strobe selection.
  rac_interval_sel #(
    .NUM_INTV(NUM_INTV)
  ) u_sel (
    .interval(ctrl_r.interval),
    .rollover_strobe(rollover_strobe),
    .feb29_selected(alarm_feb29),
    .leap_year(leap_year),
    .fire(sel_fire)
  );

  // No event is produced unless the alarm is armed.
  assign alarm_evt = ctrl_r.enable && sel_fire; // [RQ1]

  // Control register update. Hardware events act after a same-cycle write,
  // so the counter and pulse follow the event, and enable keeps the written value unless auto-off clears it; software is told not to
  // write near a rollover, which keeps this rare.
  always_comb begin
    ctrl_nxt = ctrl_r;
    auto_off = 1'b0;
    if (wr_ctrl) begin
      ctrl_nxt.enable = req.wdata[RAC_BIT_ENABLE];
      ctrl_nxt.wrap = req.wdata[RAC_BIT_WRAP];
      ctrl_nxt.interval = req.wdata[RAC_INTV_LSB+:4];
      ctrl_nxt.count = req.wdata[RAC_CNT_LSB+:8];
      if (!ctrl_r.enable) begin
        ctrl_nxt.pulse_init = req.wdata[RAC_BIT_PULSE_INIT]; // [RQ5] [RQ6]
      end
    end
    if (alarm_evt) begin
      ctrl_nxt.pulse_init = !ctrl_r.pulse_init; // [RQ14]
      if (ctrl_r.count == RAC_CNT_MIN) begin
        if (ctrl_r.wrap) begin
          ctrl_nxt.count = RAC_CNT_MAX; // [RQ2]
        end else begin
          ctrl_nxt.count = RAC_CNT_MIN; // [RQ3]
          ctrl_nxt.enable = 1'b0; // [RQ4]
          auto_off = 1'b1;
        end
      end else begin
        ctrl_nxt.count = ctrl_r.count - 8'h01; // [RQ14]
      end
    end
  end

  // Other resets leave the alarm settings untouched.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= RAC_CTRL_RST; // [RQ12]
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Read-unsafe flag: safe only beyond the guard window, registered once.
  always_comb begin
    unsafe_nxt = (32'(ticks_to_rollover) <= RAC_SYNC_GUARD); // [RQ8]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unsafe_r <= 1'b1;
    end else begin
      unsafe_r <= unsafe_nxt;
    end
  end

  // Interrupt status: set wins over a write-one-to-clear in the same cycle.
  // A control write that lands while the module is on and the flag is raised is recorded, since the
  // outcome of such a write can race a rollover.
  always_comb begin
    stat_set = '0;
    stat_set[RAC_IRQ_ALARM] = alarm_evt;
    stat_set[RAC_IRQ_AUTO_OFF] = auto_off;
    stat_set[RAC_IRQ_UNSAFE_WR] = wr_ctrl && clock_module_on && unsafe_r; // [RQ11]
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~req.wdata[RAC_IRQ_W-1:0];
    end
    stat_nxt = stat_nxt | stat_set;
    mask_nxt = wr_mask ? req.wdata[RAC_IRQ_W-1:0] : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // Interrupt state follows every reset, unlike the alarm settings.
  always_ff @(posedge clk) begin
    if (srst || sys_rst) begin
      stat_r <= RAC_IRQ_RST;
      mask_r <= RAC_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Checks on the alarm behaviour. All of them run on clk and are muted
  // while the power-on reset is applied; sys_rst does not mute them,
  // because the alarm settings must ride through it unchanged.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_DISARMED_STILL: assert property ( // [RQ1]
    !ctrl_r.enable && !wr_ctrl |=> $stable(ctrl_r.count) && $stable(alarm_pulse))
    else $error("Counter or pulse moved while alarm disabled");

  AST_WRAP_TO_MAX: assert property ( // [RQ2]
    alarm_evt && ctrl_r.count == 8'h00 && ctrl_r.wrap |=> ctrl_r.count == 8'hFF && ctrl_r.enable)
    else $error("Repeat counter did not wrap to its maximum");

  AST_STOP_AT_ZERO: assert property ( // [RQ3]
    alarm_evt && ctrl_r.count == 8'h00 && !ctrl_r.wrap |=> ctrl_r.count == 8'h00)
    else $error("Repeat counter moved past zero without wrap");

  // The auto-disable flag is raised on the same edge that clears enable.
  AST_AUTO_DISARM: assert property ( // [RQ4]
    alarm_evt && ctrl_r.count == 8'h00 && !ctrl_r.wrap |=> !ctrl_r.enable && stat_r[RAC_IRQ_AUTO_OFF])
    else $error("Alarm enable not cleared after final event");

  AST_PULSE_INIT_LOAD: assert property ( // [RQ5]
    wr_ctrl && !ctrl_r.enable && !alarm_evt |=> alarm_pulse == $past(pwdata[RAC_BIT_PULSE_INIT]))
    else $error("Pulse initial value write not applied");

  AST_PULSE_INIT_LOCKED: assert property ( // [RQ6]
    ctrl_r.enable && !alarm_evt |=> alarm_pulse == $past(alarm_pulse))
    else $error("Pulse changed without an event while enabled");

  // The flag resets to one, so the edge that releases reset is left out:
  // the flag only follows the prescaler distance one cycle later.
  AST_UNSAFE_FLAG: assert property ( // [RQ8]
    !srst && ticks_to_rollover > 32 |=> !unsafe_r ##0 (st_r != RAC_ST_ANS || !pready_r ||
      paddr != 8'h00 || pwrite || !prdata_r[12] || $past(unsafe_r)))
    else $error("Read-unsafe flag set outside the guard window");

  AST_UNSAFE_NEAR: assert property ( // [RQ8]
    ticks_to_rollover <= 32 |=> unsafe_r)
    else $error("Read-unsafe flag clear inside the guard window");

  AST_RESERVED_CODE: assert property ( // [RQ9]
    ctrl_r.interval >= 4'hA |-> !alarm_evt)
    else $error("Event from a reserved interval code");

  AST_FEB29_LEAP: assert property ( // [RQ10]
    ctrl_r.interval == 4'h9 && alarm_feb29 && !leap_year |-> !alarm_evt)
    else $error("Yearly February 29 alarm outside a leap year");

  AST_POR_ONLY: assert property ( // [RQ12]
    sys_rst && !wr_ctrl && !alarm_evt |=> $stable(ctrl_r))
    else $error("Alarm settings changed by a non power-on reset");

  AST_TOP_ZERO: assert property ( // [RQ13]
    pready_r |-> prdata_r[31:16] == 16'h0000)
    else $error("Upper half of read data not zero");

  AST_EVENT_STEP: assert property ( // [RQ14]
    alarm_evt && ctrl_r.count != 8'h00 |=>
      ctrl_r.count == 8'($past(ctrl_r.count) - 8'h01) && alarm_pulse != $past(alarm_pulse))
    else $error("Event did not decrement counter and toggle pulse");

  AST_IRQ_LEVEL: assert property (
    ##1 irq_r == |(stat_r & mask_r))
    else $error("Interrupt output disagrees with status and mask");

  // Bus answers: ready for exactly one cycle, error only for a missed decode.
  // A master that waits on ready never stalls, since no wait state exists.
  AST_READY_ONE_CYCLE: assert property (
    pready_r |=> !pready_r)
    else $error("Ready held longer than one cycle");

  AST_ERR_DECODE: assert property (
    psel && !penable && st_r == RAC_ST_IDLE |=> pready_r && (pslverr_r == !$past(addr_hit)))
    else $error("Error response does not match the address decode");

  AST_UNMAPPED_ZERO: assert property (
    pready_r && pslverr_r |-> prdata_r == 32'h0000_0000)
    else $error("Unmapped access returned nonzero data");

  COV_WRAP: cover property (alarm_evt && ctrl_r.count == 8'h00 && ctrl_r.wrap);
  COV_AUTO_OFF: cover property (auto_off ##1 irq_r);
  COV_PULSE_INIT_WRITE: cover property (wr_ctrl && !ctrl_r.enable);
  COV_UNSAFE_WRITE: cover property (wr_ctrl && clock_module_on && unsafe_r);
  COV_UNMAPPED: cover property (pready_r && pslverr_r);

endmodule : rac_alarm_control
`default_nettype wire

// ==== rac_alarm_control_tb.sv ====
/*
  Self-checking testbench for the alarm control block: an APB master task
  and directed sequences with expected values built from the field layout.
  Assumes rac_pkg and rac_alarm_control are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
module rac_alarm_control_tb;
  import rac_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sys_rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [RAC_NUM_INTV-1:0] rollover_strobe = 10'h000;
  logic alarm_feb29 = 1'b0;
  logic leap_year = 1'b0;
  logic [14:0] ticks_to_rollover = 15'h0064;
  logic clock_module_on = 1'b0;
  logic alarm_pulse;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic p;
  int miscompares = 0;
  int n_tests = 0;

  // A 25 ns period gives the 40 MHz system clock.
  always #12.5 clk = ~clk;

  // Device under test with a full-width prescaler position.
  rac_alarm_control #(.PRESC_W(15), .NUM_INTV(RAC_NUM_INTV)) u_rac_alarm_control (
    .clk(clk), .srst(srst), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rollover_strobe(rollover_strobe), .alarm_feb29(alarm_feb29),
    .leap_year(leap_year), .ticks_to_rollover(ticks_to_rollover),
    .clock_module_on(clock_module_on), .alarm_pulse(alarm_pulse), .irq(irq));

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Compares with case equality so an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; pready, read data and the error flag are taken at the
  // rising edge that completes the access, as they stood just before it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares the word.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rdchk

  // One-cycle rollover strobe, taken at the second edge.
  task automatic fire(input logic [RAC_NUM_INTV-1:0] v);
    @(posedge clk);
    rollover_strobe <= v;
    @(posedge clk);
    rollover_strobe <= 10'h000;
  endtask : fire

  // Builds an alarm control word with the read-unsafe bit clear.
  function automatic logic [31:0] cw(input logic en, input logic wp, input logic pv,
    input logic [3:0] iv, input logic [7:0] c);
    return {16'h0000, en, wp, pv, 1'b0, iv, c};
  endfunction : cw

  // Main sequence; ticks stay far from rollover unless a step says otherwise.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(RAC_OFF_CTRL, 32'h00000000);
    rdchk(RAC_OFF_IRQ_MASK, 32'h00000000);
    apb(1'b1, RAC_OFF_CTRL, 32'hFFFF0305);
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, 1'b0, 4'h3, 8'h05));
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk(err, 32'h00000001);
    rdchk(8'h0C, 32'h00000000);
    fire(10'h008);
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, 1'b0, 4'h3, 8'h05));
    apb(1'b1, RAC_OFF_IRQ_MASK, 32'h00000001);
    rdchk(RAC_OFF_IRQ_MASK, 32'h00000001);
    p = 1'b0;
    // Codes 0 to 9 each fire only on their own strobe; the count steps from 5 to 4.
    for (int k = 0; k < 10; k++) begin
      apb(1'b1, RAC_OFF_CTRL, cw(1'b1, 1'b1, 1'b0, 4'(k), 8'h05));
      fire(~(10'h001 << k));
      rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, 4'(k), 8'h05));
      fire(10'h001 << k);
      p = ~p;
      rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, 4'(k), 8'h04));
      chk(alarm_pulse, p);
    end
    chk(irq, 32'h00000001);
    apb(1'b1, RAC_OFF_IRQ_STAT, 32'h00000001);
    rdchk(RAC_OFF_IRQ_STAT, 32'h00000000);
    chk(irq, 32'h00000000);
    // Yearly alarm on the leap day is skipped outside leap years.
    apb(1'b1, RAC_OFF_CTRL, cw(1'b1, 1'b1, 1'b0, RAC_INTV_YEAR, 8'h05));
    alarm_feb29 <= 1'b1;
    fire(10'h200);
    rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, RAC_INTV_YEAR, 8'h05));
    leap_year <= 1'b1;
    fire(10'h200);
    p = ~p;
    rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, RAC_INTV_YEAR, 8'h04));
    apb(1'b1, RAC_OFF_CTRL, cw(1'b1, 1'b1, ~p, RAC_INTV_YEAR, 8'h04));
    rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, RAC_INTV_YEAR, 8'h04));
    chk(alarm_pulse, p);
    // Wrap from zero, then stop at zero and auto-disable without wrap.
    apb(1'b1, RAC_OFF_CTRL, cw(1'b1, 1'b1, 1'b0, RAC_INTV_HALF_SEC, 8'h00));
    fire(10'h001);
    p = ~p;
    rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b1, p, RAC_INTV_HALF_SEC, RAC_CNT_MAX));
    apb(1'b1, RAC_OFF_CTRL, cw(1'b1, 1'b0, 1'b0, RAC_INTV_HALF_SEC, 8'h01));
    fire(10'h001);
    p = ~p;
    rdchk(RAC_OFF_CTRL, cw(1'b1, 1'b0, p, RAC_INTV_HALF_SEC, 8'h00));
    fire(10'h001);
    p = ~p;
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, RAC_INTV_HALF_SEC, 8'h00));
    rdchk(RAC_OFF_IRQ_STAT, 32'h00000003);
    fire(10'h001);
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, RAC_INTV_HALF_SEC, 8'h00));
    // Disabled again, so the pulse initial value is taken.
    apb(1'b1, RAC_OFF_CTRL, cw(1'b0, 1'b0, ~p, RAC_INTV_HALF_SEC, 8'h00));
    p = ~p;
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, RAC_INTV_HALF_SEC, 8'h00));
    chk(alarm_pulse, p);
    // A system reset clears the interrupt side but not the control word.
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, RAC_INTV_HALF_SEC, 8'h00));
    rdchk(RAC_OFF_IRQ_MASK, 32'h00000000);
    // The read-unsafe flag flips between 33 and 32 ticks from rollover.
    ticks_to_rollover <= 15'h0021;
    repeat (3) @(posedge clk);
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, 4'h0, 8'h00));
    ticks_to_rollover <= 15'h0020;
    clock_module_on <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, 4'h0, 8'h00) | (32'h1 << RAC_BIT_UNSAFE));
    rdchk(RAC_OFF_CTRL, cw(1'b0, 1'b0, p, 4'h0, 8'h00) | (32'h1 << RAC_BIT_UNSAFE));
    apb(1'b1, RAC_OFF_CTRL, cw(1'b0, 1'b0, p, 4'h0, 8'h00));
    rdchk(RAC_OFF_IRQ_STAT, 32'h00000004);
    ticks_to_rollover <= 15'h0064;
    // Power-on reset in mid-run clears the control word.
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(RAC_OFF_CTRL, 32'h00000000);
    chk(alarm_pulse, 32'h00000000);
    test_done();
  end
endmodule : rac_alarm_control_tb
`default_nettype wire

// ==== rac_interval_sel.sv ====
/*
  Interval selector: picks the rollover strobe that matches the selected
  alarm interval. Assumes one strobe per interval, each a one-cycle pulse
  from the calendar counters that already includes the time match.
*/
`timescale 1ns/10ps
`default_nettype none
module rac_interval_sel
  import rac_pkg::*;
#(
  parameter int unsigned NUM_INTV = RAC_NUM_INTV
) (
  input wire logic [3:0] interval,
  input wire logic [NUM_INTV-1:0] rollover_strobe,
  input wire logic feb29_selected,
  input wire logic leap_year,
  output logic fire
);

  // The code space holds at most sixteen intervals.
  if (NUM_INTV < 1 || NUM_INTV > 16) begin : g_chk
    $error("rac_interval_sel: NUM_INTV must be 1 to 16");
  end

  logic leap_block;

  // A yearly alarm on the 29th of February is held off outside leap years.
  assign leap_block = (interval == RAC_INTV_YEAR) && feb29_selected && !leap_year; // [RQ10]

  // Reserved codes select nothing, so no event can come from them.
  always_comb begin
    fire = 1'b0;
    if (32'(interval) < NUM_INTV) begin // [RQ9]
      fire = rollover_strobe[interval] && !leap_block;
    end
  end

endmodule : rac_interval_sel
`default_nettype wire

// ==== rac_pkg.sv ====
/*
  Shared constants, field layouts and types for the real-time clock alarm
  control block. Assumes a 32-bit APB register bus and a surrounding clock
  and calendar that supply rollover strobes and the prescaler position.
*/
// Overview of operation
// RQ1 - Alarm events happen only while the alarm enable bit is set.
// RQ2 - With wrap enabled, the repeat counter rolls from 0x00 to 0xFF and continues.
// RQ3 - With wrap disabled, the repeat counter stops once it reaches zero.
// RQ4 - An event at count zero without wrap clears the alarm enable bit.
// RQ5 - While disabled, the pulse initial value is writable and sets the pulse level.
// RQ6 - While enabled, pulse initial value ignores writes and reads the live pulse.
// RQ7 - Software rereads counter until two reads match when read-unsafe is set.
// RQ8 - Read-unsafe reads zero only when more than 32 clocks from rollover.
// RQ9 - Interval codes 0 to 9 select half-second up to year; others reserved.
// RQ10 - Yearly alarm on February 29th fires only in leap years.
// RQ11 - Software avoids writing fields while module on and read-unsafe set.
// RQ12 - Alarm control register is reset only by power-on reset.
// RQ13 - Upper sixteen bits of alarm control always read as zero.
// RQ14 - Each event toggles the pulse and decrements the counter with stop or wrap.
package rac_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] RAC_OFF_CTRL = 8'h00;
  localparam logic [7:0] RAC_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] RAC_OFF_IRQ_MASK = 8'h08;

  // Field positions inside the alarm control word.
  localparam int unsigned RAC_BIT_ENABLE = 15;
  localparam int unsigned RAC_BIT_WRAP = 14;
  localparam int unsigned RAC_BIT_PULSE_INIT = 13;
  localparam int unsigned RAC_BIT_UNSAFE = 12;
  localparam int unsigned RAC_INTV_LSB = 8;
  localparam int unsigned RAC_CNT_LSB = 0;

  // Repeat counter limits and reset values.
  localparam logic [7:0] RAC_CNT_MIN = 8'h00;
  localparam logic [7:0] RAC_CNT_MAX = 8'hFF;
  localparam logic [14:0] RAC_CTRL_RST = 15'h0000;
  localparam logic [2:0] RAC_IRQ_RST = 3'h0;

  // Read-unsafe guard window, in real-time clock periods.
  localparam int unsigned RAC_SYNC_GUARD = 32;

  // Interval select codes.
  localparam logic [3:0] RAC_INTV_HALF_SEC = 4'h0;
  localparam logic [3:0] RAC_INTV_YEAR = 4'h9;
  localparam int unsigned RAC_NUM_INTV = 10;

  // Interrupt status bit positions.
  localparam int unsigned RAC_IRQ_ALARM = 0;
  localparam int unsigned RAC_IRQ_AUTO_OFF = 1;
  localparam int unsigned RAC_IRQ_UNSAFE_WR = 2;
  localparam int unsigned RAC_IRQ_W = 3;

  // Stored part of the alarm control register; read-unsafe is live.
  typedef struct packed {
    logic enable;
    logic wrap;
    logic pulse_init;
    logic [3:0] interval;
    logic [7:0] count;
  } rac_ctrl_t;

  // One APB request as driven on the bus, not registered.
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } rac_apb_req_t;

  // Bus answer sequencer states.
  typedef enum logic [1:0] {
    RAC_ST_IDLE = 2'b01,
    RAC_ST_ANS = 2'b10
  } rac_apb_st_t;

endpackage : rac_pkg
